// ---- verilog/iip_pkg.sv ----
// Package for the isolated input port: register offsets, field positions, timing constants and carriers.
// Assumes a single 200 MHz core clock and byte-wide register data on the card's local register window.
package iip_pkg;
   // Register offsets within the card window
   localparam logic [7:0] OFS_ACTIVATE = 8'h00;
   localparam logic [7:0] OFS_BRIDGE_SETUP = 8'h02;
   localparam logic [7:0] OFS_IRQ_GATE = 8'h05;
   localparam logic [7:0] OFS_LEVELS0 = 8'hc0;
   localparam logic [7:0] OFS_LEVELS1 = 8'hc4;
   localparam logic [7:0] OFS_LEVELS2 = 8'hc8;
   localparam logic [7:0] OFS_LEVELS3 = 8'hcc;
   localparam logic [7:0] OFS_DEBOUNCE = 8'hd0;
   localparam logic [7:0] OFS_FLAGS_LOW = 8'hd0;
   localparam logic [7:0] OFS_EDGE_CFG = 8'hd4;
   localparam logic [7:0] OFS_FLAGS_HIGH = 8'hd4;
   localparam logic [7:0] OFS_FLAGS_CLEAR = 8'hd8;
   // Write values and field positions
   localparam logic [7:0] GATE_OPEN_VAL = 8'h10;
   localparam logic [7:0] GATE_SHUT_VAL = 8'h00;
   localparam int ACTIVATE_BIT = 0;
   localparam int DEB_P0_LSB = 0;
   localparam int DEB_P1_LSB = 4;
   localparam int CFG_EN0_BIT = 0;
   localparam int CFG_EN1_BIT = 1;
   localparam int CFG_FALL0_BIT = 2;
   localparam int CFG_FALL1_BIT = 3;
   // Reset values
   localparam logic [2:0] DEB_FACTOR_RST = 3'h0;
   localparam logic [3:0] EDGE_CFG_RST = 4'h0;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   // Timing: one debounce sample every 20 ms
   localparam int CLK_HZ = 200_000_000;
   localparam int SAMPLE_MS = 20;
   localparam int SAMPLE_CYCLES = (CLK_HZ / 1000) * SAMPLE_MS;

   // Host register access carrier
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iip_req_type;
endpackage

// ---- verilog/iip_sample_tick.sv ----
// Free-running divider that pulses once per debounce sample interval.
// Assumes core_clk and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module iip_sample_tick
   import iip_pkg::*;
#(
   parameter int PERIOD = SAMPLE_CYCLES
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Sample pulse
   output logic tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } iip_tick_state_type;
   iip_tick_state_type st_r;
   iip_tick_state_type st_nxt;

   // Count down and pulse at wrap
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == 32'h0)
      begin
         st_nxt.cnt = 32'(PERIOD - 1);
         st_nxt.tick = 1'b1;
      end
      else
         st_nxt.cnt = st_r.cnt - 32'h1;
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick = st_r.tick;
endmodule
`default_nettype wire

// ---- verilog/iip_debounce.sv ----
// Debounce filter for one 8-bit port: accepts a level after a chosen count of equal samples.
// Assumes inputs already synchronised to core_clk and a sample pulse from the divider.
`timescale 1ns/1ps
`default_nettype none
module iip_debounce
   import iip_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Control
   input wire logic tick,
   input wire logic [2:0] factor,
   // Levels
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] filtered
);
   typedef struct packed {
      logic [WIDTH-1:0][2:0] run;
      logic [WIDTH-1:0] level;
   } iip_deb_state_type;
   iip_deb_state_type st_r;
   iip_deb_state_type st_nxt;

   // Per-channel run counter of samples that differ from the accepted level
   always_comb
   begin
      st_nxt = st_r;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (factor == 3'h0)
         begin
            st_nxt.level[i] = raw[i];
            st_nxt.run[i] = 3'h0;
         end
         else if (tick)
         begin
            if (raw[i] == st_r.level[i])
               st_nxt.run[i] = 3'h0;
            else if (st_r.run[i] + 3'h1 >= factor)
            begin
               st_nxt.level[i] = raw[i];
               st_nxt.run[i] = 3'h0;
            end
            else
               st_nxt.run[i] = st_r.run[i] + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign filtered = st_r.level;
endmodule
`default_nettype wire

// ---- verilog/iip_top.sv ----
// Isolated 32-channel input port with debounce on ports 0 and 1 and edge interrupt flags on channels 0-15.
// Assumes a byte register port from the PCI bridge, sampled on core_clk, and raw asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none
module iip_top
   import iip_pkg::*;
#(
   parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port from the bridge
   input wire iip_req_type req, // Offsets from the window base held at 14h in bridge_config_space
   output logic [7:0] rdata,
   output logic rvalid,
   // Field inputs
   input wire logic [31:0] isolated_input_n,
   // Status and interrupt
   output logic card_active,
   output logic inta_n
);
   typedef struct packed {
      logic [31:0] sync1;
      logic [31:0] sync2;
      logic active;
      logic gate;
      logic [2:0] deb0;
      logic [2:0] deb1;
      logic [3:0] cfg;
      logic [15:0] prev;
      logic prev_ok;
      logic [15:0] flags;
      logic [7:0] rdata;
      logic rvalid;
      logic inta_n;
   } iip_state_type;
   iip_state_type st_r;
   iip_state_type st_nxt;

   logic tick;
   logic [7:0] filt0;
   logic [7:0] filt1;
   logic [31:0] levels;
   logic [15:0] rise;
   logic [15:0] fall;
   logic [15:0] hit;
   logic wr_clear;

   // Select byte from the current levels for a port read
   function automatic logic [7:0] port_byte(input logic [31:0] lv, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         OFS_LEVELS0: r = lv[7:0];
         OFS_LEVELS1: r = lv[15:8];
         OFS_LEVELS2: r = lv[23:16];
         OFS_LEVELS3: r = lv[31:24];
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // 20 ms sample pulse shared by both filters
   iip_sample_tick #(.PERIOD(SAMPLE_PERIOD)) u_tick
   (
      .core_clk(core_clk),
      .reset(reset),
      .tick(tick)
   );

   // Filters on ports 0 and 1 only
   iip_debounce #(.WIDTH(8)) u_deb0
   (
      .core_clk(core_clk),
      .reset(reset),
      .tick(tick),
      .factor(st_r.deb0),
      .raw(st_r.sync2[7:0]),
      .filtered(filt0)
   );
   iip_debounce #(.WIDTH(8)) u_deb1
   (
      .core_clk(core_clk),
      .reset(reset),
      .tick(tick),
      .factor(st_r.deb1),
      .raw(st_r.sync2[15:8]),
      .filtered(filt1)
   );

   // Levels seen by software and by the edge_change_detector
   always_comb
   begin
      levels[7:0] = (st_r.deb0 != 3'h0) ? filt0 : st_r.sync2[7:0];
      levels[15:8] = (st_r.deb1 != 3'h0) ? filt1 : st_r.sync2[15:8];
      levels[31:16] = st_r.sync2[31:16];
   end

   // Edge_change_detector on channels 0-15 only
   always_comb
   begin
      rise = levels[15:0] & ~st_r.prev;
      fall = ~levels[15:0] & st_r.prev;
      hit[7:0] = st_r.cfg[CFG_FALL0_BIT] ? fall[7:0] : rise[7:0];
      hit[15:8] = st_r.cfg[CFG_FALL1_BIT] ? fall[15:8] : rise[15:8];
      if (!st_r.prev_ok || !st_r.active)
         hit = 16'h0000;
   end

   assign wr_clear = req.wr && (req.addr == OFS_FLAGS_CLEAR);

   // Register decode, flag update and interrupt line
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.sync1 = isolated_input_n;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.prev = levels[15:0];
      st_nxt.prev_ok = 1'b1;
      st_nxt.rvalid = 1'b0;
      if (req.wr)
      begin
         unique case (req.addr)
            OFS_ACTIVATE:
               if (req.wdata[ACTIVATE_BIT])
                  st_nxt.active = 1'b1;
            OFS_IRQ_GATE:
               if (req.wdata == GATE_OPEN_VAL)
                  st_nxt.gate = 1'b1;
               else if (req.wdata == GATE_SHUT_VAL)
                  st_nxt.gate = 1'b0;
            OFS_DEBOUNCE:
            begin
               st_nxt.deb0 = req.wdata[DEB_P0_LSB +: 3];
               st_nxt.deb1 = req.wdata[DEB_P1_LSB +: 3];
            end
            OFS_EDGE_CFG: st_nxt.cfg = req.wdata[3:0];
            default: ;
         endcase
      end
      // Clear first, then new events win
      if (wr_clear)
         st_nxt.flags = FLAGS_RST;
      st_nxt.flags = st_nxt.flags | hit;
      if (req.rd)
      begin
         st_nxt.rvalid = 1'b1;
         unique case (req.addr)
            OFS_FLAGS_LOW: st_nxt.rdata = st_r.flags[7:0];
            OFS_FLAGS_HIGH: st_nxt.rdata = st_r.flags[15:8];
            default: st_nxt.rdata = port_byte(levels, req.addr);
         endcase
      end
      st_nxt.inta_n = !(st_r.gate && st_r.active &&
         ((|st_r.flags[7:0] && st_r.cfg[CFG_EN0_BIT]) ||
          (|st_r.flags[15:8] && st_r.cfg[CFG_EN1_BIT])));
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         st_r <= '0;
         st_r.deb0 <= DEB_FACTOR_RST;
         st_r.deb1 <= DEB_FACTOR_RST;
         st_r.cfg <= EDGE_CFG_RST;
         st_r.inta_n <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // Outputs straight from flops; byte wide data covers the meaningful low byte
   assign rdata = st_r.rdata;
   assign rvalid = st_r.rvalid;
   assign card_active = st_r.active;
   assign inta_n = st_r.inta_n;

   // Assertions
   property p_flag_sticks;
      @(posedge core_clk) disable iff (reset)
      (st_r.flags[0] && !wr_clear) |=> st_r.flags[0];
   endproperty
   a_flag_sticks: assert property (p_flag_sticks) else $error("flag lost");

   property p_clear;
      @(posedge core_clk) disable iff (reset)
      (wr_clear && hit == 16'h0) |=> (st_r.flags == 16'h0);
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_inactive_quiet;
      @(posedge core_clk) disable iff (reset)
      !st_r.active |=> inta_n;
   endproperty
   a_inactive_quiet: assert property (p_inactive_quiet) else $error("irq while inactive");

   property p_gate_shut;
      @(posedge core_clk) disable iff (reset)
      !st_r.gate |=> inta_n;
   endproperty
   a_gate_shut: assert property (p_gate_shut) else $error("irq with gate shut");

   property p_irq_on;
      @(posedge core_clk) disable iff (reset)
      (st_r.gate && st_r.active && st_r.cfg[0] && st_r.flags[0]) |=> !inta_n;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");

   property p_read_flags;
      @(posedge core_clk) disable iff (reset)
      (req.rd && req.addr == OFS_FLAGS_HIGH) |=> (rvalid && rdata == $past(st_r.flags[15:8]));
   endproperty
   a_read_flags: assert property (p_read_flags) else $error("flag read wrong");

   property p_read_port2;
      @(posedge core_clk) disable iff (reset)
      (req.rd && req.addr == OFS_LEVELS2) |=> (rdata == $past(st_r.sync2[23:16]));
   endproperty
   a_read_port2: assert property (p_read_port2) else $error("port read wrong");

   property p_rise;
      @(posedge core_clk) disable iff (reset)
      (st_r.active && st_r.prev_ok && !st_r.cfg[2] && !st_r.prev[0] && levels[0]) |=> st_r.flags[0];
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge missed");

   property p_raw_pass;
      @(posedge core_clk) disable iff (reset)
      (req.rd && req.addr == OFS_LEVELS0 && st_r.deb0 == 3'h0) |=> (rdata == $past(st_r.sync2[7:0]));
   endproperty
   a_raw_pass: assert property (p_raw_pass) else $error("raw pass broken");

   property p_fall;
      @(posedge core_clk) disable iff (reset)
      (st_r.active && st_r.prev_ok && st_r.cfg[CFG_FALL0_BIT] && st_r.prev[0] && !levels[0]) |=> st_r.flags[0];
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge missed");

   property p_fall_ignores_rise;
      @(posedge core_clk) disable iff (reset)
      (st_r.cfg[CFG_FALL0_BIT] && !st_r.flags[0] && !st_r.prev[0] && levels[0]) |=> !st_r.flags[0];
   endproperty
   a_fall_ignores_rise: assert property (p_fall_ignores_rise) else $error("rise flagged in falling mode");

   property p_inactive_no_flag;
      @(posedge core_clk) disable iff (reset)
      (!st_r.active && st_r.flags == 16'h0000) |=> (st_r.flags == 16'h0000);
   endproperty
   a_inactive_no_flag: assert property (p_inactive_no_flag) else $error("flag set while inactive");

   property p_read_low;
      @(posedge core_clk) disable iff (reset)
      (req.rd && req.addr == OFS_FLAGS_LOW) |=> (rvalid && rdata == $past(st_r.flags[7:0]));
   endproperty
   a_read_low: assert property (p_read_low) else $error("low flag read wrong");

   property p_read_port3;
      @(posedge core_clk) disable iff (reset)
      (req.rd && req.addr == OFS_LEVELS3) |=> (rdata == $past(st_r.sync2[31:24]));
   endproperty
   a_read_port3: assert property (p_read_port3) else $error("port 3 read wrong");

   property p_rvalid_pulse;
      @(posedge core_clk) disable iff (reset)
      !req.rd |=> !rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer without request");

   property p_activate;
      @(posedge core_clk) disable iff (reset)
      (req.wr && req.addr == OFS_ACTIVATE && req.wdata[ACTIVATE_BIT]) |=> card_active;
   endproperty
   a_activate: assert property (p_activate) else $error("activate write lost");

   property p_active_holds;
      @(posedge core_clk) disable iff (reset)
      card_active |=> card_active;
   endproperty
   a_active_holds: assert property (p_active_holds) else $error("card dropped out of active");

   property p_gate_open;
      @(posedge core_clk) disable iff (reset)
      (req.wr && req.addr == OFS_IRQ_GATE && req.wdata == GATE_OPEN_VAL) |=> st_r.gate;
   endproperty
   a_gate_open: assert property (p_gate_open) else $error("gate did not open");

   property p_gate_close;
      @(posedge core_clk) disable iff (reset)
      (req.wr && req.addr == OFS_IRQ_GATE && req.wdata == GATE_SHUT_VAL) |=> !st_r.gate;
   endproperty
   a_gate_close: assert property (p_gate_close) else $error("gate did not close");

   property p_port1_irq;
      @(posedge core_clk) disable iff (reset)
      (st_r.gate && st_r.active && st_r.cfg[CFG_EN1_BIT] && (|st_r.flags[15:8])) |=> !inta_n;
   endproperty
   a_port1_irq: assert property (p_port1_irq) else $error("port 1 irq missing");

   property p_ports_off;
      @(posedge core_clk) disable iff (reset)
      (!st_r.cfg[CFG_EN0_BIT] && !st_r.cfg[CFG_EN1_BIT]) |=> inta_n;
   endproperty
   a_ports_off: assert property (p_ports_off) else $error("irq with both ports disabled");

   property p_deb_cfg;
      @(posedge core_clk) disable iff (reset)
      (req.wr && req.addr == OFS_DEBOUNCE) |=>
         (st_r.deb0 == $past(req.wdata[2:0]) && st_r.deb1 == $past(req.wdata[6:4]));
   endproperty
   a_deb_cfg: assert property (p_deb_cfg) else $error("debounce factors wrong");

   property p_hold_level;
      @(posedge core_clk) disable iff (reset)
      (st_r.deb0 != 3'h0 && !tick) |=> (filt0 == $past(filt0));
   endproperty
   a_hold_level: assert property (p_hold_level) else $error("filtered level moved off a sample");

   property p_raw_follow;
      @(posedge core_clk) disable iff (reset)
      (st_r.deb0 == 3'h0) |=> (filt0 == $past(st_r.sync2[7:0]));
   endproperty
   a_raw_follow: assert property (p_raw_follow) else $error("unfiltered port lags raw level");

   property p_read_filtered;
      @(posedge core_clk) disable iff (reset)
      (req.rd && req.addr == OFS_LEVELS0 && st_r.deb0 != 3'h0) |=> (rdata == $past(filt0));
   endproperty
   a_read_filtered: assert property (p_read_filtered) else $error("filtered read wrong");
endmodule
`default_nettype wire

// ---- tb/iip_host_model.sv ----
// Host-side model: driver software issuing byte register accesses to the card.
// Assumes strobes are taken at the rising edge and a read answers with rvalid.
`timescale 1ns/1ps
`default_nettype none
module iip_host_model
   import iip_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Register port
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output var iip_req_type req
);
   // Idle bus: strobes low, address and data bits turned over
   initial req = '{rd: 1'b0, wr: 1'b0, addr: 8'hff, wdata: 8'hff};

   // One byte write, strobe held across one rising edge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge core_clk);
      req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // One byte read, answer awaited under a bounded count
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge core_clk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge core_clk);
      req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
      n = 0;
      while (rvalid !== 1'b1 && n < 4)
      begin
         @(negedge core_clk);
         n++;
      end
      d = (rvalid === 1'b1) ? rdata : 8'hxx;
   endtask

   // Bridge setup before anything else
   task automatic setup_bridge();
      wr_reg(OFS_BRIDGE_SETUP, 8'h00);
   endtask

   // Handler finishing an interrupt
   task automatic ack_irq();
      wr_reg(OFS_FLAGS_CLEAR, 8'h5a);
   endtask
endmodule
`default_nettype wire

// ---- tb/isolated_input_port_with_edge_irq_tb.sv ----
// Self-checking bench for the isolated input port top.
// Assumes the host model drives the register port; the bench drives field pins.
`timescale 1ns/1ps
`default_nettype none
module isolated_input_port_with_edge_irq_tb;
   import iip_pkg::*;
   logic core_clk;
   logic reset;
   iip_req_type req;
   logic [7:0] rdata;
   logic rvalid;
   logic [31:0] pins;
   logic card_active;
   logic inta_n;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   logic [7:0] d;

   // Short sample period keeps debounce runs brief
   iip_top #(.SAMPLE_PERIOD(10)) iip_top_i (.core_clk(core_clk), .reset(reset), .req(req), .rdata(rdata),
      .rvalid(rvalid), .isolated_input_n(pins), .card_active(card_active), .inta_n(inta_n));
   iip_host_model iip_host_model_i (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid), .req(req));

   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Comparison and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic set_pins(input logic [31:0] v);
      @(negedge core_clk);
      pins = v;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      iip_host_model_i.rd_reg(a, d);
      check(d, exp);
   endtask

   // Card stays inactive until bit 0 of the activate register is set
   task automatic t_activate();
      check(card_active, 1'b0);
      check(inta_n, 1'b1);
      iip_host_model_i.setup_bridge();
      iip_host_model_i.wr_reg(OFS_ACTIVATE, 8'h00);
      idle(3);
      check(card_active, 1'b0);
      iip_host_model_i.wr_reg(OFS_ACTIVATE, 8'h01);
      idle(3);
      check(card_active, 1'b1);
      $display("test activate done");
   endtask

   // Four level ports, raw with factor zero, plus an unmapped read
   task automatic t_levels();
      set_pins(32'ha5c3_1e7f);
      idle(6);
      for (int i = 0; i < 4; i++)
         rd_chk(OFS_LEVELS0 + 8'(4 * i), pins[8 * i +: 8]);
      rd_chk(8'h10, 8'h00);
      $display("test levels done");
   endtask

   // Edge flags, port enables, gate and clear
   task automatic t_edges();
      set_pins(32'h0);
      iip_host_model_i.wr_reg(OFS_EDGE_CFG, 8'h0b);
      iip_host_model_i.wr_reg(OFS_IRQ_GATE, GATE_OPEN_VAL);
      iip_host_model_i.ack_irq();
      idle(6);
      set_pins(32'h0000_0208);
      idle(8);
      check(inta_n, 1'b0);
      rd_chk(OFS_FLAGS_LOW, 8'h08);
      rd_chk(OFS_FLAGS_HIGH, 8'h00);
      set_pins(32'h0001_0000);
      idle(8);
      rd_chk(OFS_FLAGS_HIGH, 8'h02);
      rd_chk(OFS_FLAGS_LOW, 8'h08);
      iip_host_model_i.wr_reg(OFS_IRQ_GATE, GATE_SHUT_VAL);
      idle(4);
      check(inta_n, 1'b1);
      iip_host_model_i.wr_reg(OFS_IRQ_GATE, GATE_OPEN_VAL);
      idle(4);
      check(inta_n, 1'b0);
      iip_host_model_i.ack_irq();
      idle(4);
      check(inta_n, 1'b1);
      rd_chk(OFS_FLAGS_LOW, 8'h00);
      rd_chk(OFS_FLAGS_HIGH, 8'h00);
      iip_host_model_i.wr_reg(OFS_EDGE_CFG, 8'h04);
      set_pins(32'h0001_0001);
      idle(8);
      rd_chk(OFS_FLAGS_LOW, 8'h00);
      set_pins(32'h0001_0000);
      idle(8);
      rd_chk(OFS_FLAGS_LOW, 8'h01);
      check(inta_n, 1'b1);
      $display("test edges done");
   endtask

   // Port 0 factor 3 with spare bits set, port 1 unfiltered
   task automatic t_debounce();
      set_pins(32'h0001_0000);
      iip_host_model_i.wr_reg(OFS_DEBOUNCE, 8'h8b);
      idle(60);
      set_pins(32'h0001_0101);
      idle(10);
      rd_chk(OFS_LEVELS0, 8'h00);
      rd_chk(OFS_LEVELS1, 8'h01);
      idle(50);
      rd_chk(OFS_LEVELS0, 8'h01);
      $display("test debounce done");
   endtask

   // Hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   // Main sequence
   initial
   begin
      reset = 1'b1;
      pins = 32'h0;
      repeat (20) @(negedge core_clk);
      reset = 1'b0;
      t_activate();
      t_levels();
      t_edges();
      t_debounce();
      complete_run();
   end
endmodule
`default_nettype wire
